// ### rtl/scs_pkg.sv
// How it works
// [RULE1] Select 11: direct clock input passes straight through
// [RULE2] Crystal bypass with factor 1 equals direct
// [RULE3] Select 10, bypass 1: oscillator through prescaler
// [RULE4] Prescaler divides oscillator by field plus one
// [RULE5] Factor 1: output follows oscillator duty cycle
// [RULE6] Largest prescaler factor is 1024
// [RULE7] Select 10, bypass 0: PLL enabled, drives clock
// [RULE8] PLL factor is N over P times K2
// [RULE9] Select 00: wakeup clock drives system clock
// [RULE10] Prescaler field ten bits, factors 1 to 1024
package scs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] SYS_CFG_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] PLL_CFG_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] PLL_DIV_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Clock source select codes
    localparam logic [1:0] SEL_WAKEUP = 2'h0;
    localparam logic [1:0] SEL_OSC_PLL = 2'h2;
    localparam logic [1:0] SEL_DIRECT = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Field widths
    localparam int unsigned SEL_W = 2;
    localparam int unsigned K1_W = 10;
    localparam int unsigned P_W = 4;
    localparam int unsigned N_W = 8;
    localparam int unsigned K2_W = 7;
    localparam int unsigned DEN_W = P_W + K2_W + 1;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned SEL_LSB = 0;
    localparam int unsigned VCO_BYPASS_BIT = 0;
    localparam int unsigned OSC_INT_BIT = 1;
    localparam int unsigned K1_LSB = 16;
    localparam int unsigned P_LSB = 0;
    localparam int unsigned N_LSB = 8;
    localparam int unsigned K2_LSB = 16;
    localparam int unsigned ST_SEL_LSB = 0;
    localparam int unsigned ST_PLL_EN_BIT = 2;
    localparam int unsigned ST_CLK_BIT = 3;
    localparam int unsigned ST_NUM_LSB = 4;
    localparam int unsigned ST_DEN_LSB = 16;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
    localparam logic VCO_BYPASS_RST = 1'b1;
    localparam logic OSC_INT_RST = 1'b0;
    localparam logic [K1_W-1:0] K1_RST = 10'h000;
    localparam logic [P_W-1:0] P_RST = 4'h0;
    localparam logic [N_W-1:0] N_RST = 8'h00;
    localparam logic [K2_W-1:0] K2_RST = 7'h00;

    ////////////////////////////////////////////////////////////////////////
    // Clock inputs, in synchroniser order
    localparam int unsigned NUM_CLK_IN = 5;
    localparam int unsigned CI_DIRECT = 0;
    localparam int unsigned CI_CRYSTAL = 1;
    localparam int unsigned CI_INTERNAL = 2;
    localparam int unsigned CI_WAKEUP = 3;
    localparam int unsigned CI_PLL = 4;

    typedef struct packed {
        logic [SEL_W-1:0] clock_source_select;
        logic vco_bypass;
        logic osc_internal;
        logic [K1_W-1:0] prescaler_divide_field;
        logic [P_W-1:0] pll_input_divider_field;
        logic [N_W-1:0] pll_multiplier_field;
        logic [K2_W-1:0] pll_output_divider_field;
    } scs_cfg_t;

    typedef struct packed {
        logic enable;
        logic [P_W-1:0] input_divider;
        logic [N_W-1:0] multiplier;
        logic [K2_W-1:0] output_divider;
    } scs_pll_t;

endpackage

// ### rtl/scs_clock_select.sv
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module scs_clock_select
    import scs_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic AWVALID,
    output logic AWREADY,
    // AXI4-Lite write data
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic [DATA_W/8-1:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    input wire logic ARVALID,
    output logic ARREADY,
    // AXI4-Lite read data
    output logic [DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Clock sources, asynchronous to CLK
    input wire logic DIRECT_CLOCK_INPUT,
    input wire logic CRYSTAL_INPUT,
    input wire logic INTERNAL_OSC_INPUT,
    input wire logic WAKEUP_CLOCK_INPUT,
    input wire logic PLL_CLOCK_INPUT,
    // PLL control and system clock
    output scs_pll_t PLL_CTRL,
    output logic SYS_CLOCK
);

    ////////////////////////////////////////////////////////////////////////
    // Clock input synchronisers; stage one feeds only stage two
    logic [NUM_CLK_IN-1:0] sync_a;
    logic [NUM_CLK_IN-1:0] sync_b;
    logic [NUM_CLK_IN-1:0] clk_in_raw;

    assign clk_in_raw[CI_DIRECT] = DIRECT_CLOCK_INPUT;
    assign clk_in_raw[CI_CRYSTAL] = CRYSTAL_INPUT;
    assign clk_in_raw[CI_INTERNAL] = INTERNAL_OSC_INPUT;
    assign clk_in_raw[CI_WAKEUP] = WAKEUP_CLOCK_INPUT;
    assign clk_in_raw[CI_PLL] = PLL_CLOCK_INPUT;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= clk_in_raw;
            sync_b <= sync_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers and AXI4-Lite slave
    scs_cfg_t cfg, next_cfg;
    logic aw_held, next_aw_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic w_held, next_w_held;
    logic [DATA_W-1:0] w_data, next_w_data;
    logic [DATA_W/8-1:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [DATA_W-1:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic sys_clock;

    logic aw_take, w_take, do_write, ar_take;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W/8-1:0] wr_strb;
    logic [DATA_W-1:0] sys_word, pll_word, div_word, stat_word;
    logic [DATA_W-1:0] sys_new, pll_new, div_new;
    logic [DEN_W-1:0] pll_den;
    logic [N_W:0] pll_num;
    logic pll_enable;

    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [DATA_W/8-1:0] strb
    );
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int i = 0; i < DATA_W / 8; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign AWREADY = !aw_held && !bvalid;
    assign WREADY = !w_held && !bvalid;
    assign ARREADY = !rvalid;
    assign aw_take = AWVALID && AWREADY;
    assign w_take = WVALID && WREADY;
    assign ar_take = ARVALID && ARREADY;
    assign wr_addr = aw_held ? aw_addr : AWADDR;
    assign wr_data = w_held ? w_data : WDATA;
    assign wr_strb = w_held ? w_strb : WSTRB;
    assign do_write = (aw_held || aw_take) && (w_held || w_take) && !bvalid;
    // Byte-lane merge of each writable register word with the incoming write
    assign sys_new = merge(sys_word, wr_data, wr_strb);
    assign pll_new = merge(pll_word, wr_data, wr_strb);
    assign div_new = merge(div_word, wr_data, wr_strb);

    // Factors are field plus one; the ratio N/(P*K2) goes to software
    assign pll_num = {1'b0, cfg.pll_multiplier_field} + (N_W+1)'(1); // RULE8
    assign pll_den = DEN_W'((P_W+1)'(cfg.pll_input_divider_field) + (P_W+1)'(1))
        * DEN_W'((K2_W+1)'(cfg.pll_output_divider_field) + (K2_W+1)'(1)); // RULE8
    assign pll_enable = (cfg.clock_source_select == SEL_OSC_PLL) && !cfg.vco_bypass; // RULE7

    always_comb begin
        sys_word = '0;
        sys_word[SEL_LSB +: SEL_W] = cfg.clock_source_select;
        pll_word = '0;
        pll_word[VCO_BYPASS_BIT] = cfg.vco_bypass;
        pll_word[OSC_INT_BIT] = cfg.osc_internal;
        pll_word[K1_LSB +: K1_W] = cfg.prescaler_divide_field; // RULE10
        div_word = '0;
        div_word[P_LSB +: P_W] = cfg.pll_input_divider_field;
        div_word[N_LSB +: N_W] = cfg.pll_multiplier_field;
        div_word[K2_LSB +: K2_W] = cfg.pll_output_divider_field;
        stat_word = '0;
        stat_word[ST_SEL_LSB +: SEL_W] = cfg.clock_source_select;
        stat_word[ST_PLL_EN_BIT] = pll_enable;
        stat_word[ST_CLK_BIT] = sys_clock;
        stat_word[ST_NUM_LSB +: N_W+1] = pll_num;
        stat_word[ST_DEN_LSB +: DEN_W] = pll_den;
    end

    always_comb begin
        next_cfg = cfg;
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (bvalid && BREADY) begin
            next_bvalid = 1'b0;
        end
        if (aw_take) begin
            next_aw_held = 1'b1;
            next_aw_addr = AWADDR;
        end
        if (w_take) begin
            next_w_held = 1'b1;
            next_w_data = WDATA;
            next_w_strb = WSTRB;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (wr_addr == SYS_CFG_OFS) begin
                next_cfg.clock_source_select = sys_new[SEL_LSB +: SEL_W];
            end else if (wr_addr == PLL_CFG_OFS) begin
                next_cfg.vco_bypass = pll_new[VCO_BYPASS_BIT];
                next_cfg.osc_internal = pll_new[OSC_INT_BIT];
                next_cfg.prescaler_divide_field = pll_new[K1_LSB +: K1_W]; // RULE10
            end else if (wr_addr == PLL_DIV_OFS) begin
                next_cfg.pll_input_divider_field = div_new[P_LSB +: P_W];
                next_cfg.pll_multiplier_field = div_new[N_LSB +: N_W];
                next_cfg.pll_output_divider_field = div_new[K2_LSB +: K2_W];
            end else if (wr_addr == STATUS_OFS) begin
                next_bresp = RESP_OKAY;
            end else begin
                next_bresp = RESP_SLVERR;
            end
        end
        if (rvalid && RREADY) begin
            next_rvalid = 1'b0;
        end
        if (ar_take) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            if (ARADDR == SYS_CFG_OFS) begin
                next_rdata = sys_word;
            end else if (ARADDR == PLL_CFG_OFS) begin
                next_rdata = pll_word;
            end else if (ARADDR == PLL_DIV_OFS) begin
                next_rdata = div_word;
            end else if (ARADDR == STATUS_OFS) begin
                next_rdata = stat_word;
            end else begin
                next_rdata = '0;
                next_rresp = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg.clock_source_select <= SEL_RST;
            cfg.vco_bypass <= VCO_BYPASS_RST;
            cfg.osc_internal <= OSC_INT_RST;
            cfg.prescaler_divide_field <= K1_RST;
            cfg.pll_input_divider_field <= P_RST;
            cfg.pll_multiplier_field <= N_RST;
            cfg.pll_output_divider_field <= K2_RST;
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            cfg <= next_cfg;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    assign BVALID = bvalid;
    assign BRESP = bresp;
    assign RVALID = rvalid;
    assign RDATA = rdata;
    assign RRESP = rresp;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and source selection
    // Sources are oversampled at CLK, so each must run well below half of
    // CLK; the output lags its source by three cycles, four when the prescaler divides.
    logic osc_level, osc_prev, next_osc_prev, osc_rise;
    logic [K1_W-1:0] pre_cnt, next_pre_cnt;
    logic [K1_W:0] pre_half;
    logic pre_level;
    logic next_sys_clock;
    scs_pll_t pll_ctrl, next_pll_ctrl;

    // Crystal or internal source feeds the prescaler
    assign osc_level = cfg.osc_internal ? sync_b[CI_INTERNAL] : sync_b[CI_CRYSTAL]; // RULE3
    assign osc_rise = osc_level && !osc_prev;
    // High for the first half, rounded up, of each K1 oscillator periods
    assign pre_half = ((K1_W+1)'(cfg.prescaler_divide_field) + (K1_W+1)'(2)) >> 1; // RULE4

    always_comb begin
        next_osc_prev = osc_level;
        next_pre_cnt = pre_cnt;
        if (osc_rise) begin
            // Field of all ones counts 1024 periods
            if (pre_cnt >= cfg.prescaler_divide_field) begin // RULE6
                next_pre_cnt = '0;
            end else begin
                next_pre_cnt = pre_cnt + K1_W'(1); // RULE4
            end
        end
        if (cfg.prescaler_divide_field == K1_RST) begin
            pre_level = osc_level; // RULE5 RULE2
        end else begin
            pre_level = (K1_W+1)'(pre_cnt) < pre_half; // RULE4
        end
        next_sys_clock = 1'b0;
        if (cfg.clock_source_select == SEL_DIRECT) begin
            next_sys_clock = sync_b[CI_DIRECT]; // RULE1
        end else if (cfg.clock_source_select == SEL_OSC_PLL) begin
            if (cfg.vco_bypass) begin
                next_sys_clock = pre_level; // RULE3
            end else begin
                next_sys_clock = sync_b[CI_PLL]; // RULE7
            end
        end else if (cfg.clock_source_select == SEL_WAKEUP) begin
            next_sys_clock = sync_b[CI_WAKEUP]; // RULE9
        end
        next_pll_ctrl.enable = pll_enable; // RULE7
        next_pll_ctrl.input_divider = cfg.pll_input_divider_field; // RULE8
        next_pll_ctrl.multiplier = cfg.pll_multiplier_field;
        next_pll_ctrl.output_divider = cfg.pll_output_divider_field;
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            osc_prev <= 1'b0;
            pre_cnt <= '0;
            sys_clock <= 1'b0;
            pll_ctrl <= '0;
        end else begin
            osc_prev <= next_osc_prev;
            pre_cnt <= next_pre_cnt;
            sys_clock <= next_sys_clock;
            pll_ctrl <= next_pll_ctrl;
        end
    end

    assign SYS_CLOCK = sys_clock;
    assign PLL_CTRL = pll_ctrl;

endmodule

// ### dv/scs_clock_select_asserts.sv
`timescale 1ns/1ns
module scs_clock_select_asserts
    import scs_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Register bus
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    // Clock path
    input wire logic DIRECT_CLOCK_INPUT,
    input wire logic WAKEUP_CLOCK_INPUT,
    input wire logic PLL_CLOCK_INPUT,
    input wire scs_pll_t PLL_CTRL,
    input wire logic SYS_CLOCK
);
    logic [1:0] sel, next_sel;
    logic byp, next_byp;
    logic [2:0] age, next_age;
    logic wr_hit;
    // Mirror assumes full-word writes with address and data taken together
    assign wr_hit = AWVALID && AWREADY && WVALID && WREADY;
    always_comb begin
        next_sel = sel;
        next_byp = byp;
        next_age = (age == 3'h7) ? age : age + 3'h1;
        if (wr_hit && AWADDR == SYS_CFG_OFS) begin
            next_sel = WDATA[1:0];
            next_age = 3'h0;
        end
        if (wr_hit && AWADDR == PLL_CFG_OFS) begin
            next_byp = WDATA[VCO_BYPASS_BIT];
            next_age = 3'h0;
        end
    end
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sel <= SEL_RST;
            byp <= VCO_BYPASS_RST;
            age <= 3'h0;
        end else begin
            sel <= next_sel;
            byp <= next_byp;
            age <= next_age;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_wr;
        AWVALID && AWREADY && WVALID && WREADY;
    endsequence
    sequence s_rd;
        ARVALID && ARREADY;
    endsequence
    // Path needs three settled cycles after a config change
    AST_WR_ANSWER: assert property (s_wr |=> BVALID) else $error("write not answered");
    AST_RD_ANSWER: assert property (s_rd |=> RVALID) else $error("read not answered");
    AST_WR_REFUSE: assert property (BVALID |-> !AWREADY && !WREADY) else $error("write taken while busy");
    AST_RD_REFUSE: assert property (RVALID |-> !ARREADY) else $error("read taken while busy");
    AST_DIRECT: assert property (age >= 3'h3 && sel == SEL_DIRECT
        |-> SYS_CLOCK == $past(DIRECT_CLOCK_INPUT, 3)) else $error("direct clock not passed");
    AST_WAKEUP: assert property (age >= 3'h3 && sel == SEL_WAKEUP
        |-> SYS_CLOCK == $past(WAKEUP_CLOCK_INPUT, 3)) else $error("wakeup clock not passed");
    AST_PLL_PATH: assert property (age >= 3'h3 && sel == SEL_OSC_PLL && !byp
        |-> SYS_CLOCK == $past(PLL_CLOCK_INPUT, 3)) else $error("pll clock not passed");
    AST_PLL_ENABLE: assert property (age >= 3'h1
        |-> PLL_CTRL.enable == (sel == SEL_OSC_PLL && !byp)) else $error("pll enable wrong");
endmodule
bind scs_clock_select scs_clock_select_asserts u_asserts (.CLK(CLK), .ARST_N(ARST_N), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WVALID(WVALID), .WREADY(WREADY),
    .BVALID(BVALID), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
    .DIRECT_CLOCK_INPUT(DIRECT_CLOCK_INPUT), .WAKEUP_CLOCK_INPUT(WAKEUP_CLOCK_INPUT),
    .PLL_CLOCK_INPUT(PLL_CLOCK_INPUT), .PLL_CTRL(PLL_CTRL), .SYS_CLOCK(SYS_CLOCK));

// ### dv/scs_clock_sources.sv
`timescale 1ns/1ns
// Free-running oscillators; half periods in 20 ns steps so edges fall on CLK low
module scs_clock_sources #(
    parameter int HALF_DIRECT = 5,
    parameter int HALF_CRYSTAL = 4,
    parameter int HALF_INTERNAL = 6,
    parameter int HALF_WAKEUP = 9,
    parameter int HALF_PLL = 7
) (
    // Source clocks
    output logic direct_clk,
    output logic crystal_clk,
    output logic internal_clk,
    output logic wakeup_clk,
    output logic pll_clk
);
    initial begin
        {direct_clk, crystal_clk, internal_clk, wakeup_clk, pll_clk} = 5'h00;
    end
    always #(HALF_DIRECT * 20) direct_clk = ~direct_clk;
    always #(HALF_CRYSTAL * 20) crystal_clk = ~crystal_clk;
    always #(HALF_INTERNAL * 20) internal_clk = ~internal_clk;
    always #(HALF_WAKEUP * 20) wakeup_clk = ~wakeup_clk;
    always #(HALF_PLL * 20) pll_clk = ~pll_clk;
endmodule

// ### dv/scs_clock_select_test.sv
`timescale 1ns/1ns
module scs_clock_select_test import scs_pkg::*;;
    logic CLK, ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SYS_CLOCK;
    logic [ADDR_W-1:0] AWADDR, ARADDR;
    logic [DATA_W-1:0] WDATA, RDATA;
    logic [1:0] BRESP, RRESP;
    logic dclk, xclk, iclk, wclk, pclk;
    logic [31:0] k;
    scs_pll_t PLL_CTRL;
    int n_fail, tests_run;
    scs_clock_sources src (.direct_clk(dclk), .crystal_clk(xclk), .internal_clk(iclk), .wakeup_clk(wclk),
        .pll_clk(pclk));
    scs_clock_select dut (.CLK(CLK), .ARST_N(ARST_N), .AWADDR(AWADDR), .AWPROT(3'h0), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .DIRECT_CLOCK_INPUT(dclk), .CRYSTAL_INPUT(xclk), .INTERNAL_OSC_INPUT(iclk),
        .WAKEUP_CLOCK_INPUT(wclk), .PLL_CLOCK_INPUT(pclk), .PLL_CTRL(PLL_CTRL), .SYS_CLOCK(SYS_CLOCK));
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        int t;
        t = 0;
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge CLK);
            t++;
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
        end while (!(BVALID === 1'b1) && t < 50);
        BREADY <= 1'b0;
        chk("write answered", 32'h1, {31'h0, BVALID});
        chk("write response", {30'h0, er}, {30'h0, BRESP});
        @(posedge CLK);
    endtask
    task automatic rd(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] e,
        input logic [31:0] m, input logic [1:0] er);
        int t;
        t = 0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge CLK);
            t++;
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
        end while (!(RVALID === 1'b1) && t < 50);
        RREADY <= 1'b0;
        chk("read answered", 32'h1, {31'h0, RVALID});
        chk(what, e & m, RDATA & m);
        chk("read response", {30'h0, er}, {30'h0, RRESP});
        @(posedge CLK);
    endtask
    // First rise after a change may be partial, so two rises are skipped
    task automatic per_chk(input string what, input logic [31:0] ep, input logic [31:0] eh);
        logic [31:0] p, h;
        int t;
        p = 0;
        h = 0;
        t = 0;
        repeat (2) begin
            while (SYS_CLOCK !== 1'b0 && t < 40000) begin @(posedge CLK); t++; end
            while (SYS_CLOCK !== 1'b1 && t < 40000) begin @(posedge CLK); t++; end
        end
        while (SYS_CLOCK === 1'b1 && t < 40000) begin @(posedge CLK); t++; p++; h++; end
        while (SYS_CLOCK === 1'b0 && t < 40000) begin @(posedge CLK); t++; p++; end
        chk({what, " period"}, ep, p);
        chk({what, " high time"}, eh, h);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h00;
        {AWADDR, ARADDR, WDATA} = '0;
        n_fail = 0;
        tests_run = 0;
        repeat (12) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
        rd("select reset", SYS_CFG_OFS, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
        rd("pll config reset", PLL_CFG_OFS, 32'h1, 32'hFFFFFFFF, RESP_OKAY);
        rd("pll divider reset", PLL_DIV_OFS, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
        rd("status reset", STATUS_OFS, 32'h00010010, 32'h0FFF1FF7, RESP_OKAY);
        per_chk("wakeup", 32'h12, 32'h9);
        wr(SYS_CFG_OFS, 32'h3, RESP_OKAY);
        per_chk("direct", 32'hA, 32'h5);
        wr(PLL_CFG_OFS, 32'h1, RESP_OKAY);
        wr(SYS_CFG_OFS, 32'h2, RESP_OKAY);
        per_chk("factor one", 32'h8, 32'h4);
        for (k = 32'h1; k < 32'h6; k = k + 32'h1) begin
            wr(PLL_CFG_OFS, {6'h0, k[9:0], 16'h0001}, RESP_OKAY);
            per_chk("crystal divided", 32'h8 * (k + 32'h1), 32'h8 * ((k + 32'h2) / 32'h2));
        end
        wr(PLL_CFG_OFS, 32'h00030003, RESP_OKAY);
        per_chk("internal divided", 32'h30, 32'h18);
        wr(PLL_CFG_OFS, 32'hFFFFFFFD, RESP_OKAY);
        rd("widest field", PLL_CFG_OFS, 32'h03FF0001, 32'hFFFFFFFF, RESP_OKAY);
        per_chk("largest factor", 32'h2000, 32'h1000);
        wr(PLL_DIV_OFS, 32'h00020701, RESP_OKAY);
        wr(PLL_CFG_OFS, 32'h0, RESP_OKAY);
        per_chk("pll", 32'hE, 32'h7);
        rd("pll status", STATUS_OFS, 32'h00060086, 32'h0FFF1FF7, RESP_OKAY);
        chk("pll control", {12'h0, 1'b1, 4'h1, 8'h07, 7'h02}, {12'h0, PLL_CTRL});
        wr(8'h10, 32'h3, RESP_SLVERR);
        rd("unmapped", 8'h10, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        // Unused select code holds the output low
        wr(SYS_CFG_OFS, 32'h1, RESP_OKAY);
        repeat (4) @(posedge CLK);
        chk("select one level", 32'h0, {31'h0, SYS_CLOCK});
        wr(SYS_CFG_OFS, 32'h0, RESP_OKAY);
        rd("pll off", STATUS_OFS, 32'h0, 32'h7, RESP_OKAY);
        per_chk("wakeup again", 32'h12, 32'h9);
        print_verdict();
    end
    // Whole run needs about 25000 cycles
    initial begin
        #2000000;
        n_fail++;
        print_verdict();
    end
endmodule
